// [pkg/lpd_regs.vh]
// Constants for the LIN preparing-frame and identifier-assignment decoder.
// Assumes a 125 MHz core clock and a byte receiver on the same clock.
`ifndef LPD_REGS_VH
`define LPD_REGS_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define LPD_OFS_CTRL 8'h00
`define LPD_OFS_STATUS 8'h04
`define LPD_OFS_ERRCNT 8'h08
`define LPD_OFS_SLOT_BASE 8'h40
`define LPD_OFS_SLOT_LAST 8'h7c

// ****************************************
// Field positions and reset values
// ****************************************
`define LPD_CTRL_ADDR_MSB 6
`define LPD_CTRL_ENABLE_BIT 8
`define LPD_CTRL_CLEAR_BIT 9
`define LPD_CTRL_RESET 32'h0000_0100
`define LPD_SLOT_VALID_BIT 8

// ****************************************
// Frame constants
// ****************************************
`define LPD_ID_COMMAND 6'h3c
`define LPD_ID_EXTENDED 6'h3f
`define LPD_APP_CMD_MARK 8'h80
`define LPD_CMD_ASSIGN 7'h11
`define LPD_FILL_BYTE 8'hff
`define LPD_PREP_SLOT 4'h8
`define LPD_LEN_SHORT 4'h2
`define LPD_LEN_LONG 4'h8
`define LPD_SLOTS 16

`endif

// [core/lpd_decoder.v]
// LIN slave decoder for preparing frames and dynamic identifier assignment.
// Assumes a byte receiver on core_clk that pulses once per received identifier
// and once per following byte; it need not know the frame length.
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "lpd_regs.vh"

// Functional notes
// - Preparation arms only the very next frame.
// - Take node address and command from preparation.
// - Accept two-byte preparation on slot-8 identifier.
// - Two-byte format: bit5 zero, marked cmd, address.
// - Accept eight-byte preparation on identifier 0x3C.
// - Eight-byte: 0x80, command, address, five FF.
// - Identifier is six content plus two parity.
// - 0x3C and 0x3F never stored as assigned.
// - Assignment stores identifier at pointer-selected slot.
// - Four identifier/pointer pairs per assignment frame.
// - Assignment: byte1 0x80, byte2 marked 0x11.
// - Broad zero stores always, else address match.
// - Unpack bytes four to six as documented.
// - Unpack bytes seven and eight as documented.
// - Checksum is inverted carry sum over data.
// - Parity bits six and seven as specified.
// - Indirect read ignored unless just prepared.
module lpd_decoder (
	input wire core_clk,
	input wire rst_n,
	input wire linIdValid,
	input wire [7:0] linId,
	input wire linByteValid,
	input wire [7:0] linByte,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg respondStrobe_ff,
	output reg [6:0] respondCmd_ff,
	output reg prepPending_ff,
	output reg assignStrobe_ff
);

	// ****************************************
	// Helper functions
	// ****************************************
	function parityOk;
		input [7:0] id;
		begin
			parityOk = (id[6] == (id[0] ^ id[1] ^ id[2] ^ id[4])) &&
				(id[7] == ~(id[1] ^ id[3] ^ id[4] ^ id[5]));
		end
	endfunction

	function [7:0] sumCarry;
		input [7:0] acc;
		input [7:0] b;
		reg [8:0] s;
		begin
			s = {1'b0, acc} + {1'b0, b};
			sumCarry = s[7:0] + {7'h00, s[8]};
		end
	endfunction

	// Reserved identifiers never enter the table, or a later header could alias a command frame.
	function idStorable;
		input [5:0] id;
		begin
			idStorable = (id != `LPD_ID_COMMAND) && (id != `LPD_ID_EXTENDED);
		end
	endfunction

	// Counters stop at all ones so software never sees a wrapped small value.
	function [7:0] satInc;
		input [7:0] cnt;
		begin
			satInc = (cnt == 8'hff) ? cnt : cnt + 8'h01;
		end
	endfunction

	localparam ST_IDLE = 3'b001;
	localparam ST_DATA = 3'b010;
	localparam ST_CHK = 3'b100;

	// ****************************************
	// Storage and state
	// ****************************************
	reg [2:0] state_ff;
	reg [3:0] byteIdx_ff;
	reg [3:0] frameLen_ff;
	reg longFrame_ff;
	reg [7:0] sum_ff;
	reg [7:0] dataBuf [0:7];
	reg [5:0] slotId [0:`LPD_SLOTS-1];
	reg [`LPD_SLOTS-1:0] slotValid_ff;
	reg [6:0] pendCmd_ff;
	reg [6:0] nodeAddr_ff;
	reg enable_ff;
	reg [7:0] parityErr_ff;
	reg [7:0] checksumErr_ff;
	reg [7:0] assignCnt_ff;
	reg [6:0] lastCmd_ff;

	wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wbWrite = wbReq & wb_we_i;
	wire slotHit = (wb_adr_i >= `LPD_OFS_SLOT_BASE) && (wb_adr_i <= `LPD_OFS_SLOT_LAST);
	wire [3:0] slotSel = wb_adr_i[5:2];
	wire clearSlots = wbWrite && (wb_adr_i == `LPD_OFS_CTRL) && wb_sel_i[1] && wb_dat_i[`LPD_CTRL_CLEAR_BIT];

	// ****************************************
	// Header classification
	// ****************************************
	wire idGood = parityOk(linId);
	wire isCmdId = (linId[5:0] == `LPD_ID_COMMAND);
	wire isPrepId = slotValid_ff[`LPD_PREP_SLOT] && (linId[5:0] == slotId[`LPD_PREP_SLOT]) &&
		~linId[5];

	// ****************************************
	// Payload decoding
	// ****************************************
	wire [7:0] b1 = dataBuf[0];
	wire [7:0] b2 = dataBuf[1];
	wire [7:0] b3 = dataBuf[2];
	wire [7:0] b4 = dataBuf[3];
	wire [7:0] b5 = dataBuf[4];
	wire [7:0] b6 = dataBuf[5];
	wire [7:0] b7 = dataBuf[6];
	wire [7:0] b8 = dataBuf[7];
	wire [7:0] sumNext = sumCarry(sum_ff, linByte);
	wire chkGood = (linByte == ~sum_ff);
	wire fillOk = (b4 == `LPD_FILL_BYTE) && (b5 == `LPD_FILL_BYTE) && (b6 == `LPD_FILL_BYTE) &&
		(b7 == `LPD_FILL_BYTE) && (b8 == `LPD_FILL_BYTE);
	wire appMark = (b1 == `LPD_APP_CMD_MARK);
	wire isAssign = longFrame_ff && appMark && (b2 == {1'b1, `LPD_CMD_ASSIGN});
	wire assignMine = ~b3[7] || (b3[6:0] == nodeAddr_ff);
	wire isPrep8 = longFrame_ff && appMark && b2[7] && b3[7] && fillOk &&
		(b2[6:0] != `LPD_CMD_ASSIGN);
	wire isPrep2 = ~longFrame_ff && b1[7] && b2[7];
	wire [6:0] prepCmd = longFrame_ff ? b2[6:0] : b1[6:0];
	wire [6:0] prepAddr = longFrame_ff ? b3[6:0] : b2[6:0];

	// The four pairs are packed across byte boundaries.
	wire [5:0] asgId1 = {b5[1:0], b4[7:4]};
	wire [3:0] asgPtr1 = b4[3:0];
	wire [5:0] asgId2 = {b6[3:0], b5[7:6]};
	wire [3:0] asgPtr2 = b5[5:2];
	wire [5:0] asgId3 = b7[5:0];
	wire [3:0] asgPtr3 = b6[7:4];
	wire [5:0] asgId4 = b8[7:2];
	wire [3:0] asgPtr4 = {b8[1:0], b7[7:6]};
	wire store1 = idStorable(asgId1);
	wire store2 = idStorable(asgId2);
	wire store3 = idStorable(asgId3);
	wire store4 = idStorable(asgId4);

	wire frameDone = (state_ff == ST_CHK) && linByteValid && ~linIdValid;
	wire frameOk = frameDone && chkGood && enable_ff;
	wire doAssign = frameOk && isAssign && assignMine;
	wire doPrep = frameOk && (isPrep8 || isPrep2) && (prepAddr == nodeAddr_ff);

	// ****************************************
	// Frame receive sequencer
	// ****************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			byteIdx_ff <= 4'h0;
			frameLen_ff <= 4'h0;
			longFrame_ff <= 1'b0;
			sum_ff <= 8'h00;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					state_ff <= ST_IDLE;
				end
				ST_DATA: begin
					if (linByteValid) begin
						sum_ff <= sumNext;
						byteIdx_ff <= byteIdx_ff + 4'h1;
						if (byteIdx_ff + 4'h1 == frameLen_ff) begin
							state_ff <= ST_CHK;
						end
					end
				end
				ST_CHK: begin
					if (linByteValid) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
			// A new header always resynchronises, so a truncated frame is dropped.
			if (linIdValid) begin
				byteIdx_ff <= 4'h0;
				sum_ff <= 8'h00;
				if (idGood && enable_ff && (isCmdId || isPrepId)) begin
					state_ff <= ST_DATA;
					longFrame_ff <= isCmdId;
					frameLen_ff <= isCmdId ? `LPD_LEN_LONG : `LPD_LEN_SHORT;
				end else begin
					state_ff <= ST_IDLE;
				end
			end
		end
	end

	always @(posedge core_clk) begin
		if ((state_ff == ST_DATA) && linByteValid && ~linIdValid) begin
			dataBuf[byteIdx_ff[2:0]] <= linByte;
		end
	end

	// ****************************************
	// Identifier table
	// ****************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slotValid_ff <= {`LPD_SLOTS{1'b0}};
		end else begin
			// Clear first, then set: a store in the clearing cycle survives, so no assignment is lost.
			if (clearSlots) begin
				slotValid_ff <= {`LPD_SLOTS{1'b0}};
			end
			if (doAssign) begin
				// Later pairs win when two pairs name the same slot.
				if (store1) begin
					slotValid_ff[asgPtr1] <= 1'b1;
				end
				if (store2) begin
					slotValid_ff[asgPtr2] <= 1'b1;
				end
				if (store3) begin
					slotValid_ff[asgPtr3] <= 1'b1;
				end
				if (store4) begin
					slotValid_ff[asgPtr4] <= 1'b1;
				end
			end
		end
	end

	always @(posedge core_clk) begin
		if (doAssign) begin
			if (store1) begin
				slotId[asgPtr1] <= asgId1;
			end
			if (store2) begin
				slotId[asgPtr2] <= asgId2;
			end
			if (store3) begin
				slotId[asgPtr3] <= asgId3;
			end
			if (store4) begin
				slotId[asgPtr4] <= asgId4;
			end
		end
	end

	// ****************************************
	// Preparation and response arming
	// ****************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prepPending_ff <= 1'b0;
			pendCmd_ff <= 7'h00;
			respondStrobe_ff <= 1'b0;
			respondCmd_ff <= 7'h00;
			assignStrobe_ff <= 1'b0;
			lastCmd_ff <= 7'h00;
		end else begin
			respondStrobe_ff <= 1'b0;
			assignStrobe_ff <= doAssign;
			if (linIdValid) begin
				// The header right after a preparation is the only one it may answer.
				prepPending_ff <= 1'b0;
				if (prepPending_ff && idGood) begin
					respondStrobe_ff <= 1'b1;
					respondCmd_ff <= pendCmd_ff;
					lastCmd_ff <= pendCmd_ff;
				end
			end else if (doPrep) begin
				prepPending_ff <= 1'b1;
				pendCmd_ff <= prepCmd;
			end
		end
	end

	// ****************************************
	// Error and activity counters
	// ****************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			parityErr_ff <= 8'h00;
			checksumErr_ff <= 8'h00;
			assignCnt_ff <= 8'h00;
		end else if (wbWrite && (wb_adr_i == `LPD_OFS_ERRCNT)) begin
			// Any write clears all three counters together, so software reads a consistent set.
			parityErr_ff <= 8'h00;
			checksumErr_ff <= 8'h00;
			assignCnt_ff <= 8'h00;
		end else begin
			if (linIdValid && !idGood) parityErr_ff <= satInc(parityErr_ff);
			if (frameDone && !chkGood) checksumErr_ff <= satInc(checksumErr_ff);
			if (doAssign) assignCnt_ff <= satInc(assignCnt_ff);
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			nodeAddr_ff <= 7'h00;
			enable_ff <= 1'b1;
		end else begin
			wb_ack_o <= wbReq;
			wb_dat_o <= 32'h0000_0000;
			if (wbWrite && (wb_adr_i == `LPD_OFS_CTRL)) begin
				if (wb_sel_i[0]) nodeAddr_ff <= wb_dat_i[`LPD_CTRL_ADDR_MSB:0];
				if (wb_sel_i[1]) enable_ff <= wb_dat_i[`LPD_CTRL_ENABLE_BIT];
			end
			if (wbReq && !wb_we_i) begin
				if (wb_adr_i == `LPD_OFS_CTRL) begin
					wb_dat_o <= {23'h000000, enable_ff, 1'b0, nodeAddr_ff};
				end else if (wb_adr_i == `LPD_OFS_STATUS) begin
					wb_dat_o <= {1'b0, lastCmd_ff, 1'b0, pendCmd_ff, 5'h00, state_ff, 7'h00, prepPending_ff};
				end else if (wb_adr_i == `LPD_OFS_ERRCNT) begin
					wb_dat_o <= {8'h00, assignCnt_ff, checksumErr_ff, parityErr_ff};
				end else if (slotHit) begin
					wb_dat_o <= {23'h000000, slotValid_ff[slotSel], 2'b00, slotId[slotSel]};
				end
			end
		end
	end

endmodule

// [bench/lpd_chk.sv]
// Assertions on the decoder's frame-side outputs.
// Bound to lpd_decoder; one clock, one reset.
`timescale 1ns/1ns
// ***
// Checker
// ***
module lpd_chk (
	input wire core_clk,
	input wire rst_n,
	input wire linIdValid,
	input wire linByteValid,
	input wire prepPending_ff,
	input wire respondStrobe_ff,
	input wire [6:0] respondCmd_ff,
	input wire assignStrobe_ff
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_clr; linIdValid |=> !prepPending_ff; endproperty
	a_clr: assert property (p_clr) else $error("pending kept");
	property p_fall; $fell(prepPending_ff) |-> $past(linIdValid); endproperty
	a_fall: assert property (p_fall) else $error("pending lost");
	property p_resp; respondStrobe_ff |-> $past(linIdValid) && $past(prepPending_ff); endproperty
	a_resp: assert property (p_resp) else $error("stray answer");
	property p_once; respondStrobe_ff |=> !respondStrobe_ff [*2]; endproperty
	a_once: assert property (p_once) else $error("answer repeated");
	property p_hold; !respondStrobe_ff |-> $stable(respondCmd_ff); endproperty
	a_hold: assert property (p_hold) else $error("command moved");
	property p_rise; $rose(prepPending_ff) |-> $past(linByteValid) && !$past(linIdValid); endproperty
	a_rise: assert property (p_rise) else $error("pending early");
	property p_asg; assignStrobe_ff |-> $past(linByteValid) || $past(linByteValid, 2); endproperty
	a_asg: assert property (p_asg) else $error("stray store");
	property p_kind; assignStrobe_ff |-> !$rose(prepPending_ff); endproperty
	a_kind: assert property (p_kind) else $error("store armed");
	cover property (respondStrobe_ff);
	cover property (assignStrobe_ff);
	cover property ($fell(prepPending_ff));
endmodule

// [bench/lpd_mst.sv]
// LIN master model feeding the decoder a byte stream.
// Assumes one byte is taken per edge with its strobe high.
`timescale 1ns/1ns
// ***
// Master
// ***
module lpd_mst (
	input wire core_clk,
	output logic linIdValid = 0,
	output logic [7:0] linId = 8'h00,
	output logic linByteValid = 0,
	output logic [7:0] linByte = 8'h00
);
	// Released lines show the inverse value, so a stale byte never passes for a new one.
	task automatic raw(input logic [7:0] idByte);
		@(posedge core_clk);
		linIdValid <= 1;
		linId <= idByte;
		@(posedge core_clk);
		linIdValid <= 0;
		linId <= ~idByte;
	endtask
	task automatic hdr(input logic [5:0] id);
		raw({~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id});
	endtask
	task automatic send(input logic [5:0] id, input int n, input logic [63:0] d, input int gap, input logic bad);
		logic [8:0] s;
		logic [7:0] b;
		s = 0;
		hdr(id);
		for (int i = 0; i <= n; i++) begin
			b = (i < n) ? d[63 - 8 * i -: 8] : ~s[7:0] ^ {7'h0, bad};
			s = s + b;
			s = s[7:0] + s[8];
			linByteValid <= 1;
			linByte <= b;
			@(posedge core_clk);
			if (gap > 0) begin
				linByteValid <= 0;
				linByte <= ~b;
				repeat (gap) @(posedge core_clk);
			end
		end
		linByteValid <= 0;
		linByte <= ~b;
	endtask
endmodule

// [bench/tb_top.sv]
// Top bench for the LIN preparing and assignment decoder.
// Assumes lpd_decoder, lpd_mst and lpd_chk compile first.
`timescale 1ns/1ns
`include "lpd_regs.vh"
// ***
// Bench
// ***
module tb_top;
	logic core_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0] wb_adr_i = 8'h00, linId, linByte;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [6:0] respondCmd_ff;
	logic wb_ack_o, linIdValid, linByteValid, respondStrobe_ff, prepPending_ff, assignStrobe_ff;
	int n_errors = 0, total_checks = 0, cycles = 0;
	always #4 core_clk = ~core_clk;
	lpd_mst u_lpd_mst (.core_clk, .linIdValid, .linId, .linByteValid, .linByte);
	lpd_decoder u_lpd_decoder (.core_clk, .rst_n, .linIdValid, .linId, .linByteValid, .linByte,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.respondStrobe_ff, .respondCmd_ff, .prepPending_ff, .assignStrobe_ff);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask
	task automatic slot(input int p, input logic [31:0] e, input logic [31:0] m);
		wb(0, `LPD_OFS_SLOT_BASE + 8'(4 * p), 0);
		chk("slot", rd & m, e);
	endtask
	task automatic t_regs;
		wb(0, `LPD_OFS_CTRL, 0);
		chk("ctrl", rd, `LPD_CTRL_RESET);
		wb(0, 8'h20, 0);
		chk("unmapped", rd, 0);
		wb(1, `LPD_OFS_CTRL, 32'h105);
	endtask
	// Pairs 1a/8, 3c/3, 25/a, 3f/4 packed by hand; reserved ids must not land.
	task automatic t_asg;
		u_lpd_mst.send(`LPD_ID_COMMAND, 8, {24'h809100, 40'ha80daf25fd}, 0, 0);
		#1;
		chk("store", assignStrobe_ff, 1);
		slot(8, 32'h11a, '1);
		slot(10, 32'h125, '1);
		slot(3, 0, 32'h100);
		slot(4, 0, 32'h100);
		for (int k = 0; k < 3; k++) begin
			u_lpd_mst.send(`LPD_ID_COMMAND, 8, {16'h8091, (k == 0) ? 8'h86 : 8'h85, 40'h70c001071c}, 1, k == 1);
			slot(0, (k == 2) ? 32'h107 : 0, {32{k == 2}} | 32'h100);
		end
	endtask
	task automatic pcase(input logic [5:0] id, input int n, input logic [63:0] d, input int gap, input logic bad,
		input logic pend, input logic [6:0] cmd);
		u_lpd_mst.send(id, n, d, gap, bad);
		#1;
		chk("pending", prepPending_ff, pend);
		u_lpd_mst.hdr(6'h3d);
		#1;
		chk("answer", respondStrobe_ff, pend);
		if (pend) chk("cmd", respondCmd_ff, cmd);
	endtask
	// A header with broken parity still ends a preparation but never answers it.
	task automatic t_par;
		u_lpd_mst.send(6'h1a, 2, {16'h8a85, 48'h0}, 0, 0);
		#1;
		chk("pending", prepPending_ff, 1);
		u_lpd_mst.raw(8'h3d);
		#1;
		chk("answer", respondStrobe_ff, 0);
		chk("pending", prepPending_ff, 0);
		wb(0, `LPD_OFS_STATUS, 0);
		chk("status", rd, 32'h2f0a_0100);
		wb(0, `LPD_OFS_ERRCNT, 0);
		chk("errcnt", rd, 32'h0002_0201);
	endtask
	// Disabled decoding refuses frames, and a cleared table refuses two-byte preparations.
	task automatic t_ctl;
		wb(1, `LPD_OFS_CTRL, 32'h005);
		pcase(`LPD_ID_COMMAND, 8, {24'h80af85, 40'hffffffffff}, 0, 0, 0, 7'h2f);
		wb(1, `LPD_OFS_CTRL, 32'h305);
		wb(0, `LPD_OFS_CTRL, 0);
		chk("ctrl", rd, 32'h105);
		slot(8, 0, 32'h100);
		pcase(6'h1a, 2, {16'h8385, 48'h0}, 0, 0, 0, 7'h03);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1;
		t_regs;
		t_asg;
		pcase(6'h1a, 2, {16'h8385, 48'h0}, 2, 0, 1, 7'h03);
		pcase(`LPD_ID_COMMAND, 8, {24'h80af85, 40'hffffffffff}, 0, 0, 1, 7'h2f);
		pcase(`LPD_ID_COMMAND, 8, {24'h80af86, 40'hffffffffff}, 0, 0, 0, 7'h2f);
		pcase(6'h1a, 2, {16'h8385, 48'h0}, 0, 1, 0, 7'h03);
		t_par;
		t_ctl;
		complete_run;
	end
	always @(posedge core_clk) begin
		if (++cycles == 5000) begin
			n_errors++;
			complete_run;
		end
	end
endmodule
bind lpd_decoder lpd_chk u_lpd_chk (.core_clk, .rst_n, .linIdValid, .linByteValid, .prepPending_ff,
	.respondStrobe_ff, .respondCmd_ff, .assignStrobe_ff);
